// [design/rscr_regs.sv]
`default_nettype none
module rscr_regs
   import rscr_pkg::*;
(
   input  wire logic               CLK,
   input  wire logic               RESET_N,
   input  wire logic               HSEL,
   input  wire logic [31:0]        HADDR,
   input  wire logic [1:0]         HTRANS,
   input  wire logic               HWRITE,
   input  wire logic [2:0]         HSIZE,
   input  wire logic [31:0]        HWDATA,
   input  wire logic               HREADY,
   output var  logic [31:0]        HRDATA,
   output logic                    HREADYOUT,
   output logic                    HRESP,
   input  wire logic               HW_CTRL1,
   input  wire logic               HW_CTRL2,
   input  wire logic               HW_ENABLE1,
   input  wire logic               HW_ENABLE2,
   input  wire logic               UNDERVOLT,
   input  wire logic               SEQ_STROBE,
   input  wire logic [2:0]         SEQ_SLOT,
   input  wire logic               SEQ_POWER_UP,
   output var  logic               REG_ENABLE,
   output var  logic               REG_LOW_POWER,
   output var  logic [VCODE_W-1:0] REG_VCODE,
   output var  logic [MV_W-1:0]    REG_MV,
   output var  logic               REG_DISCHARGE,
   output var  logic               REG_OUTPUT_FLOAT,
   output var  logic               REG_SWITCH_MODE,
   output var  logic [VCODE_W-1:0] PREV_SLEEP_VCODE,
   output var  logic               SYS_RESET_REQ,
   output logic                    IRQ
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   localparam int PIN_N = 5;
   localparam int P_C1 = 0;
   localparam int P_C2 = 1;
   localparam int P_E1 = 2;
   localparam int P_E2 = 3;
   localparam int P_UV = 4;
   wire  [PIN_N-1:0] pin_raw = {UNDERVOLT, HW_ENABLE2, HW_ENABLE1, HW_CTRL2, HW_CTRL1};
   logic [PIN_N-1:0] pin_meta;
   logic [PIN_N-1:0] pin_sync;
   logic [PIN_N-1:0] pin_prev;
   genvar gi;
   generate
      for (gi = 0; gi < PIN_N; gi++) begin : g_sync
         always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
               pin_meta[gi] <= 1'b0;
               pin_sync[gi] <= 1'b0;
               pin_prev[gi] <= 1'b0;
            end else begin
               pin_meta[gi] <= pin_raw[gi];
               pin_sync[gi] <= pin_meta[gi];
               pin_prev[gi] <= pin_sync[gi];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // registers and fields
   // ---------------------------------------------------------------
   logic [15:0]      prev_sleep_ctl;
   logic [15:0]      fault_ctl;
   logic [15:0]      on_ctl;
   logic [15:0]      sleep_ctl;
   logic [INT_W-1:0] int_status;
   logic [INT_W-1:0] int_mask;
   rscr_state_e      state;
   rscr_state_e      next_state;

   wire [1:0]         undervoltage_response   = fault_ctl[UV_RESP_MSB:UV_RESP_LSB];
   wire [1:0]         hw_control_source       = fault_ctl[HWC_SRC_MSB:HWC_SRC_LSB];
   wire               hw_control_voltage_pick = fault_ctl[HWC_VPICK];
   wire [1:0]         hw_control_mode         = fault_ctl[HWC_MODE_MSB:HWC_MODE_LSB];
   wire               output_float_select     = fault_ctl[FLOAT_BIT];
   wire               pass_switch_select      = fault_ctl[SWITCH_BIT];
   wire [2:0]         power_on_slot           = on_ctl[SLOT_MSB:SLOT_LSB];
   wire               active_low_power_select = on_ctl[MODE_BIT];
   wire [VCODE_W-1:0] active_voltage_code     = on_ctl[VCODE_MSB:VCODE_LSB];
   wire [2:0]         sleep_slot              = sleep_ctl[SLOT_MSB:SLOT_LSB];
   wire               sleep_low_power_select  = sleep_ctl[MODE_BIT];
   wire [VCODE_W-1:0] sleep_voltage_code      = sleep_ctl[VCODE_MSB:VCODE_LSB];
   wire [VCODE_W-1:0] prev_sleep_voltage_code = prev_sleep_ctl[VCODE_MSB:VCODE_LSB];

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   logic        rd_wait;
   logic        wr_pend;
   logic [31:0] addr_q;
   wire         accept   = HSEL & HREADY & HTRANS[1];
   wire         wr_word  = HSIZE == HSIZE_WORD;
   wire [15:0]  wdata    = HWDATA[15:0];
   wire         wr_prev  = wr_pend & (addr_q == ADDR_PREV_SLEEP);
   wire         wr_fault = wr_pend & (addr_q == ADDR_FAULT_HWC);
   wire         wr_on    = wr_pend & (addr_q == ADDR_POWER_ON);
   wire         wr_sleep = wr_pend & (addr_q == ADDR_SLEEP);
   wire         wr_imask = wr_pend & (addr_q == ADDR_INT_MASK);
   wire         rd_stat  = rd_wait & (addr_q == ADDR_INT_STATUS);
   wire [31:0]  rd_mux   =
      (addr_q == ADDR_PREV_SLEEP) ? {16'h0000, prev_sleep_ctl} :
      (addr_q == ADDR_FAULT_HWC)  ? {16'h0000, fault_ctl} :
      (addr_q == ADDR_POWER_ON)   ? {16'h0000, on_ctl} :
      (addr_q == ADDR_SLEEP)      ? {16'h0000, sleep_ctl} :
      (addr_q == ADDR_INT_STATUS) ? {30'h0000_0000, int_status} :
      (addr_q == ADDR_INT_MASK)   ? {30'h0000_0000, int_mask} :
      (addr_q == ADDR_CHAN_STATE) ? {30'h0000_0000, state} : 32'h0000_0000;

   assign HREADYOUT = ~rd_wait;
   assign HRESP     = 1'b0;

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rd_wait <= 1'b0;
         wr_pend <= 1'b0;
         addr_q  <= 32'h0000_0000;
         HRDATA  <= 32'h0000_0000;
      end else begin
         rd_wait <= accept & ~HWRITE;
         wr_pend <= accept & HWRITE & wr_word;
         if (accept) begin
            addr_q <= HADDR;
         end
         if (rd_wait) begin
            HRDATA <= rd_mux;
         end
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         prev_sleep_ctl <= RST_PREV_SLEEP;
         fault_ctl      <= RST_FAULT_HWC;
         on_ctl         <= RST_POWER_ON;
         sleep_ctl      <= RST_SLEEP;
         int_mask       <= '0;
      end else begin
         if (wr_prev)  prev_sleep_ctl <= wdata & MASK_SLOT_REG;
         if (wr_fault) fault_ctl      <= wdata & MASK_FAULT_HWC;
         if (wr_on)    on_ctl         <= wdata & MASK_SLOT_REG;
         if (wr_sleep) sleep_ctl      <= wdata & MASK_SLOT_REG;
         if (wr_imask) int_mask       <= HWDATA[INT_W-1:0];
      end
   end

   // ---------------------------------------------------------------
   // hardware control and enable inputs
   // ---------------------------------------------------------------
   wire hwc_act = (hw_control_source == HWC_IN1 & pin_sync[P_C1]) |
                  (hw_control_source == HWC_IN2 & pin_sync[P_C2]) |
                  (hw_control_source == HWC_EITHER & (pin_sync[P_C1] | pin_sync[P_C2]));
   wire hwen_mode = (power_on_slot == SLOT_HWEN1) | (power_on_slot == SLOT_HWEN2);
   wire hwen_lvl  = (power_on_slot == SLOT_HWEN1) ? pin_sync[P_E1] : pin_sync[P_E2];
   wire hwen_old  = (power_on_slot == SLOT_HWEN1) ? pin_prev[P_E1] : pin_prev[P_E2];
   wire hwen_rise = hwen_mode & hwen_lvl & ~hwen_old;
   wire hwen_fall = hwen_mode & ~hwen_lvl & hwen_old;

   // ---------------------------------------------------------------
   // undervoltage
   // ---------------------------------------------------------------
   wire uv_event = pin_sync[P_UV] & ~pin_prev[P_UV];
   wire uv_off   = uv_event & (undervoltage_response == UV_OFF);
   wire uv_reset = uv_event & (undervoltage_response == UV_SYSRESET);
   wire [INT_W-1:0] int_set = {uv_off, uv_event};
   wire [INT_W-1:0] next_int_status = (rd_stat ? '0 : int_status) | int_set;

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         int_status    <= '0;
         SYS_RESET_REQ <= 1'b0;
      end else begin
         int_status    <= next_int_status;
         SYS_RESET_REQ <= uv_reset;
      end
   end

   assign IRQ = |(int_status & int_mask);

   // ---------------------------------------------------------------
   // timeslot sequencing
   // ---------------------------------------------------------------
   wire       on_in_range = (power_on_slot >= SLOT_FIRST) & (power_on_slot <= SLOT_LAST);
   wire       slp_disable = (sleep_slot >= SLOT_FIRST) & (sleep_slot <= SLOT_LAST);
   wire [2:0] slp_time    = (sleep_slot == SLP_TRANS5) ? TSLOT5 :
                            (sleep_slot == SLP_TRANS3) ? TSLOT3 :
                            (sleep_slot == SLP_TRANS1) ? TSLOT1 :
                            TSLOT_MIRROR - sleep_slot;
   wire       up_hit      = SEQ_STROBE & SEQ_POWER_UP;
   wire       down_hit    = SEQ_STROBE & ~SEQ_POWER_UP & (state == ST_ACTIVE) & (SEQ_SLOT == slp_time);

   always_comb begin
      next_state = state;
      if (uv_off) begin
         next_state = ST_OFF;
      end else if (hwen_mode) begin
         if (hwen_rise) begin
            next_state = ST_ACTIVE;
         end else if (hwen_fall) begin
            next_state = ST_OFF;
         end else if (down_hit) begin
            next_state = ST_SLEEP;
         end else if (up_hit & hwen_lvl & (state == ST_SLEEP)) begin
            next_state = ST_ACTIVE;
         end
      end else if (up_hit & on_in_range & (SEQ_SLOT == power_on_slot)) begin
         next_state = ST_ACTIVE;
      end else if (down_hit) begin
         next_state = slp_disable ? ST_OFF : ST_SLEEP;
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state <= ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   // ---------------------------------------------------------------
   // regulator outputs
   // ---------------------------------------------------------------
   rscr_volt_if vif ();
   rscr_volt_map u_volt_map (
      .vif (vif.conv)
   );
   wire               next_enable = (state != ST_OFF) & ~(hwc_act & (hw_control_mode == HMODE_OFF));
   wire               sw_low_power = (state == ST_SLEEP) ? sleep_low_power_select
                                                         : active_low_power_select;
   wire               hw_low_power = (hw_control_mode == HMODE_FOLLOW) ? active_low_power_select
                                                                       : 1'b1;
   wire               next_low_power = hwc_act ? hw_low_power : sw_low_power;
   wire [VCODE_W-1:0] hw_vcode = hw_control_voltage_pick ? sleep_voltage_code
                                                         : active_voltage_code;
   wire [VCODE_W-1:0] sw_vcode = (state == ST_SLEEP) ? sleep_voltage_code : active_voltage_code;
   assign vif.code = hwc_act ? hw_vcode : sw_vcode;

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         REG_ENABLE       <= 1'b0;
         REG_LOW_POWER    <= 1'b0;
         REG_VCODE        <= '0;
         REG_MV           <= MV_W'(BASE_LO_MV);
         REG_DISCHARGE    <= 1'b1;
         REG_OUTPUT_FLOAT <= 1'b0;
         REG_SWITCH_MODE  <= 1'b0;
         PREV_SLEEP_VCODE <= '0;
      end else begin
         REG_ENABLE       <= next_enable;
         REG_LOW_POWER    <= next_low_power;
         REG_VCODE        <= vif.code;
         REG_MV           <= vif.mv;
         REG_DISCHARGE    <= ~next_enable & ~output_float_select;
         REG_OUTPUT_FLOAT <= ~next_enable & output_float_select;
         REG_SWITCH_MODE  <= pass_switch_select;
         PREV_SLEEP_VCODE <= prev_sleep_voltage_code;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);

   a_volt_code_map: assert property (
      (int'(REG_VCODE) < KNEE_CODE) ? (int'(REG_MV) == BASE_LO_MV + STEP_LO_MV * int'(REG_VCODE))
                                    : (int'(REG_MV) == BASE_HI_MV + STEP_HI_MV * (int'(REG_VCODE) - KNEE_CODE)))
      else $error("voltage in mV does not match code");
   a_uv_reset_pulse: assert property (
      uv_event |=> (SYS_RESET_REQ == ($past(undervoltage_response) == UV_SYSRESET)))
      else $error("reset request does not follow response");
   a_uv_off_state: assert property (
      uv_off |=> (state == ST_OFF) ##1 !REG_ENABLE)
      else $error("undervoltage did not switch regulator off");
   a_uv_irq_raise: assert property (
      uv_event |=> int_status[INT_UV_EVENT] && (!int_mask[INT_UV_EVENT] || IRQ))
      else $error("undervoltage did not raise interrupt");
   a_hwc_none_idle: assert property (
      (hw_control_source == HWC_NONE) && !hwc_act && (state == ST_ACTIVE) && $stable(state)
      |=> REG_LOW_POWER == $past(active_low_power_select))
      else $error("hardware control acted while disabled");
   a_hwc_vpick: assert property (
      hwc_act |=> REG_VCODE == ($past(hw_control_voltage_pick) ? $past(sleep_voltage_code)
                                                                : $past(active_voltage_code)))
      else $error("hardware voltage pick wrong");
   a_hwc_mode_off: assert property (
      hwc_act && (hw_control_mode == HMODE_OFF) |=> !REG_ENABLE && (REG_DISCHARGE != REG_OUTPUT_FLOAT))
      else $error("hardware off mode left regulator on");
   a_hwc_low_power: assert property (
      hwc_act && !hw_control_mode[0] |=> REG_LOW_POWER)
      else $error("hardware mode did not force low power");
   a_float_enable: assert property (
      REG_ENABLE |-> !REG_DISCHARGE && !REG_OUTPUT_FLOAT)
      else $error("output discharged or floated while enabled");
   a_slot_never: assert property (
      (power_on_slot == SLOT_NEVER) && (state == ST_OFF) |=> state == ST_OFF)
      else $error("regulator enabled with never slot");
   a_active_mode: assert property (
      !hwc_act && (state == ST_ACTIVE) |=> REG_LOW_POWER == $past(active_low_power_select))
      else $error("active mode bit not applied");
   a_sleep_disable: assert property (
      down_hit && !hwen_mode && slp_disable |=> state == ST_OFF)
      else $error("sleep disable slot not honoured");
   a_hwen_sleep: assert property (
      down_hit && hwen_mode && !uv_off && !hwen_rise && !hwen_fall |=> state == ST_SLEEP)
      else $error("hardware enabled regulator not put to sleep");
   a_sleep_mode: assert property (
      !hwc_act && (state == ST_SLEEP) |=> REG_LOW_POWER == $past(sleep_low_power_select))
      else $error("sleep mode bit not applied");
   a_reserved_zero: assert property (
      $fell(rd_wait) |-> (HRDATA[31:16] == 16'h0000) && ((HRDATA[15:0] & ~MASK_SLOT_REG & ~MASK_FAULT_HWC) == 16'h0000))
      else $error("reserved bits read as nonzero");
   a_status_clear: assert property (
      rd_stat && (int_set == '0) |=> int_status == '0)
      else $error("status read did not clear");
   a_hwc_follow: assert property (
      hwc_act && (hw_control_mode == HMODE_FOLLOW) |=> REG_LOW_POWER == $past(active_low_power_select))
      else $error("hardware follow mode not applied");
   a_switch_copy: assert property (
      REG_SWITCH_MODE == $past(pass_switch_select))
      else $error("switch select not applied");
   a_slot_enable: assert property (
      up_hit && !hwen_mode && !uv_off && on_in_range && (SEQ_SLOT == power_on_slot) |=> state == ST_ACTIVE)
      else $error("regulator not enabled in its slot");
   a_hwen_rise: assert property (
      hwen_rise && !uv_off |=> state == ST_ACTIVE)
      else $error("hardware enable did not start regulator");
   a_sleep_enter: assert property (
      down_hit && !hwen_mode && !slp_disable && !uv_off |=> state == ST_SLEEP)
      else $error("sleep transition slot not honoured");
   a_sleep_volt: assert property (
      !hwc_act && (state == ST_SLEEP) |=> REG_VCODE == $past(sleep_voltage_code))
      else $error("sleep voltage code not applied");
   a_prev_code: assert property (
      PREV_SLEEP_VCODE == $past(prev_sleep_voltage_code))
      else $error("previous channel code not forwarded");
endmodule : rscr_regs
`default_nettype wire

// [include/rscr_pkg.sv]
`default_nettype none
package rscr_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [31:0] IDX_PREV_SLEEP = 32'h0000_407C;
   localparam logic [31:0] IDX_FAULT_HWC  = 32'h0000_407D;
   localparam logic [31:0] IDX_POWER_ON   = 32'h0000_407E;
   localparam logic [31:0] IDX_SLEEP      = 32'h0000_407F;
   localparam logic [31:0] IDX_INT_STATUS = 32'h0000_4090;
   localparam logic [31:0] IDX_INT_MASK   = 32'h0000_4091;
   localparam logic [31:0] IDX_CHAN_STATE = 32'h0000_4092;
   localparam logic [31:0] ADDR_PREV_SLEEP = IDX_PREV_SLEEP << 2;
   localparam logic [31:0] ADDR_FAULT_HWC  = IDX_FAULT_HWC << 2;
   localparam logic [31:0] ADDR_POWER_ON   = IDX_POWER_ON << 2;
   localparam logic [31:0] ADDR_SLEEP      = IDX_SLEEP << 2;
   localparam logic [31:0] ADDR_INT_STATUS = IDX_INT_STATUS << 2;
   localparam logic [31:0] ADDR_INT_MASK   = IDX_INT_MASK << 2;
   localparam logic [31:0] ADDR_CHAN_STATE = IDX_CHAN_STATE << 2;
   // ---------------------------------------------------------------
   // writable bits and reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] MASK_SLOT_REG  = 16'hE11F;
   localparam logic [15:0] MASK_FAULT_HWC = 16'hDFC0;
   localparam logic [15:0] RST_PREV_SLEEP = 16'h0100;
   localparam logic [15:0] RST_FAULT_HWC  = 16'h0200;
   localparam logic [15:0] RST_POWER_ON   = 16'h0000;
   localparam logic [15:0] RST_SLEEP      = 16'h0100;
   localparam int          INT_W          = 2;
   localparam int          INT_UV_EVENT   = 0;
   localparam int          INT_UV_OFF     = 1;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int UV_RESP_MSB = 15;
   localparam int UV_RESP_LSB = 14;
   localparam int HWC_SRC_MSB = 12;
   localparam int HWC_SRC_LSB = 11;
   localparam int HWC_VPICK   = 10;
   localparam int HWC_MODE_MSB = 9;
   localparam int HWC_MODE_LSB = 8;
   localparam int FLOAT_BIT   = 7;
   localparam int SWITCH_BIT  = 6;
   localparam int SLOT_MSB    = 15;
   localparam int SLOT_LSB    = 13;
   localparam int MODE_BIT    = 8;
   localparam int VCODE_MSB   = 4;
   localparam int VCODE_LSB   = 0;
   // ---------------------------------------------------------------
   // codes
   // ---------------------------------------------------------------
   localparam logic [1:0] UV_IGNORE   = 2'h0;
   localparam logic [1:0] UV_OFF      = 2'h1;
   localparam logic [1:0] UV_SYSRESET = 2'h2;
   localparam logic [1:0] HWC_NONE    = 2'h0;
   localparam logic [1:0] HWC_IN1     = 2'h1;
   localparam logic [1:0] HWC_IN2     = 2'h2;
   localparam logic [1:0] HWC_EITHER  = 2'h3;
   localparam logic [1:0] HMODE_OFF   = 2'h1;
   localparam logic [1:0] HMODE_FOLLOW = 2'h3;
   localparam logic [2:0] SLOT_NEVER  = 3'h0;
   localparam logic [2:0] SLOT_FIRST  = 3'h1;
   localparam logic [2:0] SLOT_LAST   = 3'h5;
   localparam logic [2:0] SLOT_HWEN1  = 3'h6;
   localparam logic [2:0] SLOT_HWEN2  = 3'h7;
   localparam logic [2:0] SLP_TRANS5  = 3'h0;
   localparam logic [2:0] SLP_TRANS3  = 3'h6;
   localparam logic [2:0] SLP_TRANS1  = 3'h7;
   localparam logic [2:0] TSLOT1      = 3'h1;
   localparam logic [2:0] TSLOT3      = 3'h3;
   localparam logic [2:0] TSLOT5      = 3'h5;
   localparam logic [2:0] TSLOT_MIRROR = 3'h6;
   localparam logic [2:0] HSIZE_WORD  = 3'h2;
   // ---------------------------------------------------------------
   // voltage map
   // ---------------------------------------------------------------
   localparam int VCODE_W    = 5;
   localparam int MV_W       = 12;
   localparam int KNEE_CODE  = 13;
   localparam int BASE_LO_MV = 1000;
   localparam int STEP_LO_MV = 50;
   localparam int BASE_HI_MV = 1700;
   localparam int STEP_HI_MV = 100;
   typedef enum logic [1:0] {ST_OFF, ST_ACTIVE, ST_SLEEP} rscr_state_e;
endpackage : rscr_pkg
`default_nettype wire

// [include/rscr_volt_if.sv]
`default_nettype none
interface rscr_volt_if;
   import rscr_pkg::*;
   logic [VCODE_W-1:0] code;
   logic [MV_W-1:0]    mv;
   modport conv (input code, output mv);
   modport user (output code, input mv);
endinterface : rscr_volt_if
`default_nettype wire

// [design/rscr_volt_map.sv]
`default_nettype none
module rscr_volt_map
   import rscr_pkg::*;
(
   rscr_volt_if.conv vif
);
   // ---------------------------------------------------------------
   // code to millivolts
   // ---------------------------------------------------------------
   wire        below_knee = int'(vif.code) < KNEE_CODE;
   wire [31:0] lo_mv      = 32'(BASE_LO_MV + STEP_LO_MV * int'(vif.code));
   wire [31:0] hi_mv      = 32'(BASE_HI_MV + STEP_HI_MV * (int'(vif.code) - KNEE_CODE));
   assign vif.mv = below_knee ? lo_mv[MV_W-1:0] : hi_mv[MV_W-1:0];
endmodule : rscr_volt_map
`default_nettype wire

// [verif/rscr_analog_model.sv]
`default_nettype none
module rscr_analog_model
(
   input  wire logic REG_ENABLE,
   input  wire logic OVERLOAD,
   output var  logic UNDERVOLT
);
   timeunit 1ns;
   timeprecision 1ps;
   // sagging output only while the stage is on
   always_comb UNDERVOLT = REG_ENABLE & OVERLOAD;
endmodule : rscr_analog_model
`default_nettype wire

// [verif/testbench.sv]
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_total++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
   import rscr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK = 0, RESET_N = 0, HSEL = 0, HWRITE = 0, HREADYOUT, HRESP, IRQ;
   logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, d;
   logic [1:0] HTRANS = 0;
   logic [2:0] HSIZE = HSIZE_WORD, SEQ_SLOT = 0;
   logic HW_CTRL1 = 0, HW_CTRL2 = 0, HW_ENABLE1 = 0, HW_ENABLE2 = 0;
   logic UNDERVOLT, SEQ_STROBE = 0, SEQ_POWER_UP = 0, ovl = 0;
   logic REG_ENABLE, REG_LOW_POWER, REG_DISCHARGE, REG_OUTPUT_FLOAT, REG_SWITCH_MODE, SYS_RESET_REQ;
   logic [VCODE_W-1:0] REG_VCODE, PREV_SLEEP_VCODE;
   logic [MV_W-1:0] REG_MV;
   int err_total = 0, checks_done = 0, rst_seen = 0;
   rscr_regs u_rscr_regs (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HW_CTRL1(HW_CTRL1), .HW_CTRL2(HW_CTRL2), .HW_ENABLE1(HW_ENABLE1),
      .HW_ENABLE2(HW_ENABLE2), .UNDERVOLT(UNDERVOLT), .SEQ_STROBE(SEQ_STROBE), .SEQ_SLOT(SEQ_SLOT),
      .SEQ_POWER_UP(SEQ_POWER_UP), .REG_ENABLE(REG_ENABLE), .REG_LOW_POWER(REG_LOW_POWER),
      .REG_VCODE(REG_VCODE), .REG_MV(REG_MV), .REG_DISCHARGE(REG_DISCHARGE),
      .REG_OUTPUT_FLOAT(REG_OUTPUT_FLOAT), .REG_SWITCH_MODE(REG_SWITCH_MODE),
      .PREV_SLEEP_VCODE(PREV_SLEEP_VCODE), .SYS_RESET_REQ(SYS_RESET_REQ), .IRQ(IRQ));
   rscr_analog_model u_rscr_analog_model (.REG_ENABLE(REG_ENABLE), .OVERLOAD(ovl), .UNDERVOLT(UNDERVOLT));
   // counts device reset request pulses
   always @(posedge CLK) begin
      if (SYS_RESET_REQ === 1'b1) rst_seen <= rst_seen + 1;
   end
   initial begin
      forever #5 CLK = ~CLK;
   end
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude
   // one bus phase, ends on the edge where ready is high
   task automatic phase(output logic [31:0] rd);
      logic r;
      int i;
      r = 0;
      for (i = 0; i < 50 && r !== 1'b1; i++) begin
         @(negedge CLK);
         r = HREADYOUT;
         rd = HRDATA;
         @(posedge CLK);
      end
      if (r !== 1'b1) begin
         err_total++;
         conclude();
      end
   endtask : phase
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      HSEL <= 1;
      HTRANS <= 2'h2;
      HWRITE <= w;
      HADDR <= a;
      phase(rd);
      HTRANS <= 2'h0;
      HWDATA <= wd;
      phase(rd);
   endtask : xfer
   task automatic wr(input logic [31:0] a, input logic [31:0] wd);
      xfer(1'b1, a, wd, d);
   endtask : wr
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0, d);
      `CHK(d, e)
   endtask : rd_chk
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
   endtask : tick
   // one sequencer timeslot strobe, then outputs settle
   task automatic strobe(input logic up, input logic [2:0] s);
      SEQ_STROBE <= 1;
      SEQ_POWER_UP <= up;
      SEQ_SLOT <= s;
      tick(1);
      SEQ_STROBE <= 0;
      tick(3);
   endtask : strobe
   initial begin
      tick(8);
      RESET_N <= 1;
      tick(1);
      `CHK({REG_ENABLE, REG_DISCHARGE, REG_OUTPUT_FLOAT, REG_SWITCH_MODE, SYS_RESET_REQ, IRQ, HRESP, HREADYOUT}, 8'h41)
      `CHK(REG_MV, 12'h3E8)
      rd_chk(ADDR_PREV_SLEEP, 32'h0000_0100);
      rd_chk(ADDR_FAULT_HWC, 32'h0000_0200);
      rd_chk(ADDR_POWER_ON, 32'h0000_0000);
      rd_chk(ADDR_SLEEP, 32'h0000_0100);
      rd_chk(32'h0001_0300, 32'h0000_0000);
      wr(ADDR_POWER_ON, 32'hFFFF_FFFF);
      rd_chk(ADDR_POWER_ON, 32'h0000_E11F);
      wr(ADDR_FAULT_HWC, 32'hFFFF_FFFF);
      rd_chk(ADDR_FAULT_HWC, 32'h0000_DFC0);
      wr(ADDR_FAULT_HWC, 32'h0000_0000);
      wr(ADDR_POWER_ON, 32'h0000_200C);
      strobe(1'b1, 3'h1);
      `CHK(REG_ENABLE, 1'b1)
      `CHK(REG_MV, 12'd1600)
      wr(ADDR_POWER_ON, 32'h0000_200D);
      tick(3);
      `CHK(REG_MV, 12'd1700)
      wr(ADDR_POWER_ON, 32'h0000_211F);
      tick(3);
      `CHK(REG_MV, 12'd3500)
      `CHK(REG_LOW_POWER, 1'b1)
      wr(ADDR_INT_MASK, 32'h0000_0001);
      ovl <= 1;
      tick(6);
      `CHK(IRQ, 1'b1)
      `CHK(REG_ENABLE, 1'b1)
      ovl <= 0;
      rd_chk(ADDR_INT_STATUS, 32'h0000_0001);
      tick(2);
      `CHK(IRQ, 1'b0)
      wr(ADDR_FAULT_HWC, 32'h0000_0900);
      HW_CTRL1 <= 1;
      tick(6);
      `CHK(REG_ENABLE, 1'b0)
      HW_CTRL1 <= 0;
      tick(6);
      `CHK(REG_ENABLE, 1'b1)
      wr(ADDR_FAULT_HWC, 32'h0000_4000);
      ovl <= 1;
      tick(6);
      `CHK(REG_ENABLE, 1'b0)
      `CHK(REG_DISCHARGE, 1'b1)
      rd_chk(ADDR_CHAN_STATE, 32'h0000_0000);
      rd_chk(ADDR_INT_STATUS, 32'h0000_0003);
      ovl <= 0;
      wr(ADDR_FAULT_HWC, 32'h0000_00C0);
      tick(2);
      `CHK(REG_OUTPUT_FLOAT, 1'b1)
      `CHK(REG_DISCHARGE, 1'b0)
      `CHK(REG_SWITCH_MODE, 1'b1)
      wr(ADDR_PREV_SLEEP, 32'hFFFF_0113);
      rd_chk(ADDR_PREV_SLEEP, 32'h0000_0113);
      tick(2);
      `CHK(PREV_SLEEP_VCODE, 5'h13)
      wr(ADDR_SLEEP, 32'h0000_0105);
      wr(ADDR_POWER_ON, 32'h0000_200A);
      strobe(1'b1, 3'h1);
      `CHK(REG_ENABLE, 1'b1)
      `CHK(REG_LOW_POWER, 1'b0)
      strobe(1'b0, 3'h5);
      `CHK(REG_VCODE, 5'h05)
      `CHK(REG_LOW_POWER, 1'b1)
      rd_chk(ADDR_CHAN_STATE, 32'h0000_0002);
      wr(ADDR_SLEEP, 32'h0000_2105);
      strobe(1'b1, 3'h1);
      strobe(1'b0, 3'h5);
      rd_chk(ADDR_CHAN_STATE, 32'h0000_0000);
      wr(ADDR_POWER_ON, 32'h0000_C00A);
      HW_ENABLE1 <= 1;
      tick(6);
      `CHK(REG_ENABLE, 1'b1)
      wr(ADDR_FAULT_HWC, 32'h0000_1400);
      HW_CTRL1 <= 1;
      tick(6);
      `CHK(REG_VCODE, 5'h0A)
      HW_CTRL2 <= 1;
      tick(6);
      `CHK(REG_VCODE, 5'h05)
      `CHK(REG_LOW_POWER, 1'b1)
      HW_CTRL1 <= 0;
      HW_CTRL2 <= 0;
      wr(ADDR_FAULT_HWC, 32'h0000_8000);
      ovl <= 1;
      tick(6);
      ovl <= 0;
      `CHK(rst_seen, 1)
      rd_chk(ADDR_INT_STATUS, 32'h0000_0001);
      strobe(1'b0, 3'h5);
      rd_chk(ADDR_CHAN_STATE, 32'h0000_0002);
      HW_ENABLE1 <= 0;
      tick(6);
      `CHK(REG_ENABLE, 1'b0)
      wr(ADDR_POWER_ON, 32'h0000_E00A);
      HW_ENABLE2 <= 1;
      tick(6);
      `CHK(REG_ENABLE, 1'b1)
      conclude();
   end
endmodule : testbench
`default_nettype wire
